//--- core/acc_unit_map.svh
`ifndef ACC_UNIT_MAP_SVH
`define ACC_UNIT_MAP_SVH

`define ACC_WIDTH        32
`define WORD_WIDTH       16
`define BIT_COUNT_MIN    6'h01
`define BIT_COUNT_MAX    6'h20
`define ACC_RESET_VALUE  32'h0000_0000
`define ACC_SIGN_BIT     31
`define STACK_DEPTH      8

`endif

//--- core/acc_unit_pkg.sv
package acc_unit_pkg;

	typedef enum logic [2:0] {
		op_none_t_val,
		formatted_bit_xor_op,
		stack_xor_op,
		word_compare_op,
		double_word_compare_op,
		formatted_bit_compare_op
	} op_code_t;

endpackage : acc_unit_pkg

//--- core/acc_stack.sv
`timescale 1ns/1ps
`include "acc_unit_map.svh"

// accumulator stack: push on load, pop on stack operations
module acc_stack #(
	parameter int DEPTH = `STACK_DEPTH,
	parameter int WIDTH = `ACC_WIDTH
) (
	input  wire logic             clk,
	input  wire logic             rstn,
	input  wire logic             push,
	input  wire logic [WIDTH-1:0] push_data,
	input  wire logic             pop,
	output logic      [WIDTH-1:0] top_data
);

	logic [WIDTH-1:0] entry_reg [DEPTH];
	logic [WIDTH-1:0] push_in   [DEPTH];
	logic [WIDTH-1:0] pop_in    [DEPTH];

	genvar g;
	generate
		for (g = 0; g < DEPTH; g++) begin : g_entry
			// neighbour taps picked at elaboration so no index leaves the array
			if (g == 0) begin : g_top
				assign push_in[g] = push_data;
			end else begin : g_below
				assign push_in[g] = entry_reg[g-1];
			end
			// the bottom level refills with zero once data moves up
			if (g == DEPTH-1) begin : g_bottom
				assign pop_in[g] = '0;
			end else begin : g_above
				assign pop_in[g] = entry_reg[g+1];
			end
			always_ff @(posedge clk or negedge rstn) begin
				if (!rstn) begin
					entry_reg[g] <= '0;
				end else if (push) begin
					entry_reg[g] <= push_in[g];
				end else if (pop) begin
					entry_reg[g] <= pop_in[g];
				end
			end
		end
	endgenerate

	assign top_data = entry_reg[0];

endmodule : acc_stack

//--- core/acc_xor_cmp_unit.sv
`timescale 1ns/1ps
`include "acc_unit_map.svh"

// Functional notes
// - formatted xor of accumulator with bit run
// - formatted ops take start bits and count
// - zero flag set when xor result zero
// - negative flag follows result bit 31
// - flags hold until rewritten by same kind
// - stack xor uses full accumulator and top
// - stack xor pops stack one level
// - word compare uses low sixteen bits
// - less flag when accumulator smaller
// - equal flag when values match
// - greater flag when accumulator larger
// - compares are plain unsigned, no conversion
// - double compare uses all 32 bits
// - formatted compare against assembled bit run
// - compares never change the accumulator
module acc_xor_cmp_unit
	import acc_unit_pkg::*;
(
	input  wire logic                    clk,
	input  wire logic                    rstn,
	input  wire logic                    op_valid,
	input  wire op_code_t                op_code,
	input  wire logic [`ACC_WIDTH-1:0]   bit_field,
	input  wire logic [5:0]              bit_count,
	input  wire logic [`WORD_WIDTH-1:0]  word_operand,
	input  wire logic [`ACC_WIDTH-1:0]   double_operand,
	input  wire logic                    acc_load,
	input  wire logic [`ACC_WIDTH-1:0]   acc_load_data,
	output logic      [`ACC_WIDTH-1:0]   acc_value,
	output logic      [`ACC_WIDTH-1:0]   stack_top,
	output logic                         less_than_flag,
	output logic                         equal_flag,
	output logic                         greater_than_flag,
	output logic                         zero_result_flag,
	output logic                         negative_result_flag,
	output logic                         count_error
);

	logic [`ACC_WIDTH-1:0] acc_reg;
	logic [`ACC_WIDTH-1:0] acc_next;
	logic [`ACC_WIDTH-1:0] field_mask;
	logic [`ACC_WIDTH-1:0] field_value;
	logic [`ACC_WIDTH-1:0] cmp_left;
	logic [`ACC_WIDTH-1:0] cmp_right;
	logic                  count_ok;
	logic                  is_xor;
	logic                  is_cmp;
	logic                  stack_pop;
	logic                  lt_reg;
	logic                  eq_reg;
	logic                  gt_reg;
	logic                  zero_reg;
	logic                  neg_reg;
	logic                  err_reg;

	// an out of range count is refused whole rather than clamped
	assign count_ok = (bit_count >= `BIT_COUNT_MIN) &&
		(bit_count <= `BIT_COUNT_MAX);

	// right aligned run, bits above count forced to zero
	always_comb begin
		if (bit_count >= `BIT_COUNT_MAX)
			field_mask = '1;
		else
			field_mask = (32'h0000_0001 << bit_count) - 32'h0000_0001;
		field_value = bit_field & field_mask;
	end

	always_comb begin
		is_xor = 1'b0;
		is_cmp = 1'b0;
		acc_next = acc_reg;
		cmp_left = acc_reg;
		cmp_right = '0;
		if (op_valid) begin
			unique case (op_code)
				formatted_bit_xor_op: begin
					is_xor = count_ok;
					acc_next = acc_reg ^ field_value;
				end
				stack_xor_op: begin
					is_xor = 1'b1;
					acc_next = acc_reg ^ stack_top;
				end
				word_compare_op: begin
					is_cmp = 1'b1;
					cmp_left = {16'h0000, acc_reg[`WORD_WIDTH-1:0]};
					cmp_right = {16'h0000, word_operand};
				end
				double_word_compare_op: begin
					is_cmp = 1'b1;
					cmp_right = double_operand;
				end
				formatted_bit_compare_op: begin
					is_cmp = count_ok;
					cmp_left = acc_reg & field_mask;
					cmp_right = field_value;
				end
				default: begin
				end
			endcase
		end
	end

	assign stack_pop = op_valid && (op_code == stack_xor_op);

	// compares leave acc untouched since only xor loads acc_next
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			acc_reg <= `ACC_RESET_VALUE;
		else if (acc_load)
			acc_reg <= acc_load_data;
		else if (is_xor)
			acc_reg <= acc_next;
	end

	// result flags only move on an xor; other ops leave them
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			zero_reg <= 1'b0;
			neg_reg <= 1'b0;
		end else if (is_xor) begin
			zero_reg <= (acc_next == '0);
			neg_reg <= acc_next[`ACC_SIGN_BIT];
		end
	end

	// unsigned compare: same bit patterns order the same in every format
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			lt_reg <= 1'b0;
			eq_reg <= 1'b0;
			gt_reg <= 1'b0;
		end else if (is_cmp) begin
			lt_reg <= cmp_left < cmp_right;
			eq_reg <= cmp_left == cmp_right;
			gt_reg <= cmp_left > cmp_right;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			err_reg <= 1'b0;
		else if (op_valid)
			err_reg <= !count_ok && (op_code == formatted_bit_xor_op ||
				op_code == formatted_bit_compare_op);
	end

	acc_stack #(
		.DEPTH(`STACK_DEPTH),
		.WIDTH(`ACC_WIDTH)
	) acc_stack_inst (
		.clk      (clk),
		.rstn     (rstn),
		.push     (acc_load),
		.push_data(acc_reg),
		.pop      (stack_pop && !acc_load),
		.top_data (stack_top)
	);

	assign acc_value = acc_reg;
	assign less_than_flag = lt_reg;
	assign equal_flag = eq_reg;
	assign greater_than_flag = gt_reg;
	assign zero_result_flag = zero_reg;
	assign negative_result_flag = neg_reg;
	assign count_error = err_reg;

	a_cmp_onehot: assert property (
		@(posedge clk) disable iff (!rstn)
		$past(is_cmp) |-> $onehot({lt_reg, eq_reg, gt_reg}))
		else $error("compare flags not one-hot");

	a_cmp_keeps_acc: assert property (
		@(posedge clk) disable iff (!rstn)
		is_cmp && !acc_load |=> $stable(acc_reg))
		else $error("compare changed accumulator");

	a_xor_zero: assert property (
		@(posedge clk) disable iff (!rstn)
		is_xor && !acc_load |=> zero_reg == (acc_reg == '0))
		else $error("zero flag wrong after xor");

	a_xor_neg: assert property (
		@(posedge clk) disable iff (!rstn)
		is_xor && !acc_load |=> neg_reg == acc_reg[`ACC_SIGN_BIT])
		else $error("negative flag wrong after xor");

	a_stack_xor: assert property (
		@(posedge clk) disable iff (!rstn)
		stack_pop && !acc_load |=>
		acc_reg == ($past(acc_reg) ^ $past(stack_top)))
		else $error("stack xor result wrong");

	a_flags_hold: assert property (
		@(posedge clk) disable iff (!rstn)
		!is_cmp |=> $stable({lt_reg, eq_reg, gt_reg}))
		else $error("compare flags moved without compare");

	a_word_lt: assert property (
		@(posedge clk) disable iff (!rstn)
		op_valid && op_code == word_compare_op &&
		acc_reg[`WORD_WIDTH-1:0] < word_operand |=> lt_reg)
		else $error("word compare less flag missing");

	a_dbl_gt: assert property (
		@(posedge clk) disable iff (!rstn)
		op_valid && op_code == double_word_compare_op &&
		acc_reg > double_operand |=> gt_reg && !eq_reg)
		else $error("double compare greater flag missing");

	a_fmt_xor: assert property (
		@(posedge clk) disable iff (!rstn)
		op_valid && op_code == formatted_bit_xor_op && count_ok &&
		!acc_load |=> acc_reg == ($past(acc_reg) ^ $past(field_value)))
		else $error("formatted xor result wrong");

	// a refused count must leave accumulator and result flags alone
	a_count_refused: assert property (
		@(posedge clk) disable iff (!rstn)
		op_valid && !count_ok && !acc_load &&
		(op_code == formatted_bit_xor_op ||
		op_code == formatted_bit_compare_op) |=>
		err_reg && $stable(acc_reg) && $stable({zero_reg, neg_reg}))
		else $error("out of range count not refused");

	// bits above the count must not take part on either side
	a_fmt_cmp_mask: assert property (
		@(posedge clk) disable iff (!rstn)
		op_valid && op_code == formatted_bit_compare_op && count_ok &&
		(acc_reg & field_mask) == (bit_field & field_mask) |=> eq_reg)
		else $error("formatted compare looked past bit count");

endmodule : acc_xor_cmp_unit

//--- dv/acc_xor_cmp_unit_tb_top.sv
`timescale 1ns/1ps
`include "acc_unit_map.svh"
module acc_xor_cmp_unit_tb_top import acc_unit_pkg::*;;
	logic        clk = 0, rstn = 0, op_valid = 0, acc_load = 0;
	op_code_t    op_code = op_none_t_val;
	logic [31:0] bit_field = 0, double_operand = 0, acc_load_data = 0;
	logic [5:0]  bit_count = 0;
	logic [15:0] word_operand = 0;
	logic [31:0] acc_value, stack_top;
	logic        lt, eq, gt, zf, nf, count_error;
	int          fails = 0, checks_done = 0;
	acc_xor_cmp_unit acc_xor_cmp_unit_inst (.clk(clk), .rstn(rstn),
		.op_valid(op_valid), .op_code(op_code), .bit_field(bit_field),
		.bit_count(bit_count), .word_operand(word_operand),
		.double_operand(double_operand), .acc_load(acc_load),
		.acc_load_data(acc_load_data), .acc_value(acc_value),
		.stack_top(stack_top), .less_than_flag(lt), .equal_flag(eq),
		.greater_than_flag(gt), .zero_result_flag(zf),
		.negative_result_flag(nf), .count_error(count_error));
	always #4 clk = ~clk;
	task chk(input logic [63:0] seen, input logic [63:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task step;
		@(posedge clk);
		#1;
	endtask : step
	// each task sets both strobes once, so back-to-back calls never
	// assign a strobe twice in one time step
	task load(input logic [31:0] v);
		op_valid = 0;
		acc_load = 1;
		acc_load_data = v;
		step;
	endtask : load
	task run(input op_code_t c, input logic [31:0] bf, input logic [5:0] n,
		input logic [31:0] opd);
		acc_load = 0;
		op_valid = 1;
		op_code = c;
		bit_field = bf;
		bit_count = n;
		word_operand = opd[15:0];
		double_operand = opd;
		step;
	endtask : run
	task idle;
		acc_load = 0;
		op_valid = 0;
		step;
	endtask : idle
	task t_stack_xor;
		load(32'h1234_5678);
		load(32'h8765_4321);
		chk(stack_top, 32'h1234_5678);
		run(stack_xor_op, 0, 0, 0);
		chk(acc_value, 32'h1234_5678 ^ 32'h8765_4321);
		chk(stack_top, 32'h0);
		chk({zf, nf}, 2'b01);
		load(32'h0000_0a5a);
		load(32'h0000_0a5a);
		run(stack_xor_op, 0, 0, 0);
		chk({acc_value, zf, nf}, {32'h0000_0000, 2'b10});
		chk(stack_top, 32'h1234_5678 ^ 32'h8765_4321);
		idle;
	endtask : t_stack_xor
	task t_fmt_xor;
		load(32'hf000_00f0);
		run(formatted_bit_xor_op, 32'hffff_ffff, 6'h04, 0);
		chk(acc_value, 32'hf000_00ff);
		chk({zf, nf}, 2'b01);
		run(formatted_bit_xor_op, 32'hffff_ffff, 6'h20, 0);
		chk(acc_value, 32'h0fff_ff00);
		run(formatted_bit_xor_op, 32'h0000_0003, 6'h01, 0);
		chk(acc_value, 32'h0fff_ff01);
		run(formatted_bit_xor_op, 32'hffff_ffff, 6'h00, 0);
		chk({acc_value, count_error}, {32'h0fff_ff01, 1'b1});
		run(formatted_bit_xor_op, 32'hffff_ffff, 6'h21, 0);
		chk({acc_value, count_error}, {32'h0fff_ff01, 1'b1});
		run(formatted_bit_xor_op, 32'h0fff_ff01, 6'h20, 0);
		chk({count_error, zf, nf}, 3'b010);
		idle;
	endtask : t_fmt_xor
	task t_cmp;
		// zero flag is set on entry and must survive the compares
		load(32'hffff_0005);
		run(word_compare_op, 0, 0, 32'h0000_0006);
		chk({lt, eq, gt}, 3'b100);
		run(word_compare_op, 0, 0, 32'h0000_0005);
		chk({lt, eq, gt}, 3'b010);
		run(word_compare_op, 0, 0, 32'h0000_0004);
		chk({lt, eq, gt}, 3'b001);
		chk({acc_value, zf}, {32'hffff_0005, 1'b1});
		load(32'h8000_0000);
		run(double_word_compare_op, 0, 0, 32'h7fff_ffff);
		chk({lt, eq, gt}, 3'b001);
		run(double_word_compare_op, 0, 0, 32'h8000_0000);
		chk({lt, eq, gt}, 3'b010);
		run(double_word_compare_op, 0, 0, 32'h8000_0001);
		chk({lt, eq, gt}, 3'b100);
		load(32'hffff_fff6);
		run(formatted_bit_compare_op, 32'hffff_fffe, 6'h04, 0);
		chk({lt, eq, gt}, 3'b100);
		run(formatted_bit_compare_op, 32'hffff_fff6, 6'h20, 0);
		chk({lt, eq, gt}, 3'b010);
		run(formatted_bit_compare_op, 32'h0000_0000, 6'h00, 0);
		chk({lt, eq, gt, count_error}, 4'b0101);
		run(formatted_bit_xor_op, 32'h0000_0009, 6'h04, 0);
		chk({acc_value, lt, eq, gt}, {32'hffff_ffff, 3'b010});
		run(op_none_t_val, 32'hffff_ffff, 6'h00, 32'h0000_0000);
		chk({acc_value, lt, eq, gt, zf, nf, count_error},
			{32'hffff_ffff, 3'b010, 2'b01, 1'b0});
		idle;
	endtask : t_cmp
	task finish_test;
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : finish_test
	initial begin
		repeat (20) @(posedge clk);
		#1;
		rstn = 1;
		chk({acc_value, lt, eq, gt, zf, nf}, 0);
		chk({stack_top, count_error}, 33'h0_0000_0000);
		t_stack_xor;
		t_fmt_xor;
		t_cmp;
		finish_test;
	end
endmodule : acc_xor_cmp_unit_tb_top
